// *** ext_irq_regs.svh ***
// register offsets, field positions and reset values of the external pin interrupt unit
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH
`define EXT_IRQ_IO_SHIFT      8'h20
`define EXT_IRQ_EXT_IO_BASE   8'h60
`define EXT_IRQ_FLAGS_OFS     8'h3C
`define EXT_IRQ_ENABLES_OFS   8'h3D
`define EXT_IRQ_SENSE_OFS     8'h69
`define EXT_IRQ_FLAGS_RST     8'h00
`define EXT_IRQ_ENABLES_RST   8'h00
`define EXT_IRQ_SENSE_RST     8'h00
`define EXT_IRQ_SENSE_PIN0_LSB 0
`define EXT_IRQ_SENSE_PIN1_LSB 2
`define EXT_IRQ_SENSE_PIN2_LSB 4
`define EXT_IRQ_SENSE_USED    6
`define EXT_IRQ_PIN_COUNT     3
`endif

// *** ext_irq_pkg.sv ***
// types shared by the external pin interrupt unit
package ext_irq_pkg;
  typedef enum logic [1:0] {
    SENSE_LOW     = 2'b00,
    SENSE_CHANGE  = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING  = 2'b11
  } sense_mode_t;
endpackage

// *** pin_sense_detect.sv ***
// per-pin sampling and trigger detection for one external interrupt pin
`timescale 1ns/1ps
module pin_sense_detect
(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // pin and mode
  input  wire logic                      pin_in,
  input  wire ext_irq_pkg::sense_mode_t  mode,
  // results
  output logic                           edge_event,
  output logic                           level_low
);
  logic sample_reg;
  logic prev_reg;

  // two sample stages; edges compare successive samples, never the raw pin
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sample_reg <= 1'b1;
      prev_reg   <= 1'b1;
    end
    else
    begin
      sample_reg <= pin_in;
      prev_reg   <= sample_reg;
    end
  end

  // a pulse held over one clock edge is always caught
  always_comb
  begin
    case (mode)
      ext_irq_pkg::SENSE_CHANGE:  edge_event = sample_reg ^ prev_reg;
      ext_irq_pkg::SENSE_FALLING: edge_event = prev_reg & ~sample_reg;
      ext_irq_pkg::SENSE_RISING:  edge_event = ~prev_reg & sample_reg;
      default:                    edge_event = 1'b0;
    endcase
  end

  // raw level path: taken straight from the pin, but the request it feeds is registered and still needs a clock edge
  assign level_low = (mode == ext_irq_pkg::SENSE_LOW) & ~pin_in;
endmodule

// *** ext_irq_bus_decode.sv ***
// address decode for the data-space and short i/o register windows
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
module ext_irq_bus_decode
(
  // access
  input  wire logic [7:0] addr,
  input  wire logic       io_space,
  // selects
  output logic            sel_flags,
  output logic            sel_enables,
  output logic            sel_sense
);
  logic [7:0] data_addr;

  // short i/o addresses sit 0x20 below the data-space ones
  assign data_addr = io_space ? 8'(addr + `EXT_IRQ_IO_SHIFT) : addr;

  always_comb
  begin
    sel_flags   = 1'b0;
    sel_enables = 1'b0;
    sel_sense   = 1'b0;
    // short i/o opcodes only reach 0x00-0x3f, never the extended area
    if (io_space && addr >= 8'h40)
      sel_flags = 1'b0;
    else if (data_addr == `EXT_IRQ_FLAGS_OFS)
      sel_flags = 1'b1;
    else if (data_addr == `EXT_IRQ_ENABLES_OFS)
      sel_enables = 1'b1;
    else if (!io_space && data_addr == `EXT_IRQ_SENSE_OFS)
      sel_sense = 1'b1;
  end
endmodule

// *** external_pin_interrupt_unit.sv ***
// external pin interrupt unit: sense select, enables, flags and requests
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
module external_pin_interrupt_unit
#(
  parameter int PINS = `EXT_IRQ_PIN_COUNT
)
(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  // external pins, read whatever their port direction
  input  wire logic [PINS-1:0] ext_irq_pin,
  // processor register access
  input  wire logic [7:0]      reg_addr,
  input  wire logic            reg_io_space,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_wdata,
  output logic [7:0]           reg_rdata,
  // processor interrupt side
  input  wire logic            global_irq_enable,
  input  wire logic [PINS-1:0] vector_entry,
  output logic [PINS-1:0]      irq_request
);
  logic [5:0]      sense_reg;
  logic [PINS-1:0] enables_reg;
  logic [PINS-1:0] flags_reg;
  logic [PINS-1:0] flags_next;
  logic [PINS-1:0] edge_event;
  logic [PINS-1:0] level_low;
  logic [PINS-1:0] level_mode;
  logic [PINS-1:0] request_next;
  logic            sel_flags;
  logic            sel_enables;
  logic            sel_sense;

  // address decode
  ext_irq_bus_decode u_decode
  (
    .addr        (reg_addr),
    .io_space    (reg_io_space),
    .sel_flags   (sel_flags),
    .sel_enables (sel_enables),
    .sel_sense   (sel_sense)
  );

  // one detector per pin, each with its own two-bit sense field
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pin
      ext_irq_pkg::sense_mode_t pin_mode;
      assign pin_mode = ext_irq_pkg::sense_mode_t'(sense_reg[2*gi +: 2]);
      assign level_mode[gi] = (pin_mode == ext_irq_pkg::SENSE_LOW);
      pin_sense_detect u_det
      (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .pin_in     (ext_irq_pin[gi]),
        .mode       (pin_mode),
        .edge_event (edge_event[gi]),
        .level_low  (level_low[gi])
      );
    end
  endgenerate

  // sense select register; bits 7:6 are not stored
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sense_reg <= 6'(`EXT_IRQ_SENSE_RST);
    else if (reg_wr && sel_sense)
      sense_reg <= reg_wdata[5:0];
  end

  // enable register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      enables_reg <= PINS'(`EXT_IRQ_ENABLES_RST);
    else if (reg_wr && sel_enables)
      enables_reg <= reg_wdata[PINS-1:0];
  end

  // flag next value: a new edge beats a clear in the same cycle
  always_comb
  begin
    flags_next = flags_reg;
    if (reg_wr && sel_flags)
      flags_next = flags_next & ~reg_wdata[PINS-1:0];
    flags_next = flags_next & ~vector_entry;
    flags_next = flags_next | edge_event;
    flags_next = flags_next & ~level_mode;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      flags_reg <= PINS'(`EXT_IRQ_FLAGS_RST);
    else
      flags_reg <= flags_next;
  end

  // requests, gated by pin enable and global enable; level follows the pin
  assign request_next = (flags_reg | level_low) & enables_reg
                        & {PINS{global_irq_enable}};

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irq_request <= '0;
    else
      irq_request <= request_next;
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd && sel_sense)
      reg_rdata <= {2'b00, sense_reg};
    else if (reg_rd && sel_enables)
      reg_rdata <= 8'(enables_reg);
    else if (reg_rd && sel_flags)
      reg_rdata <= 8'(flags_reg);
    else
      reg_rdata <= 8'h00;
  end

  // checks
  a_flag_on_edge: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (edge_event[0] && !level_mode[0]) |=> flags_reg[0])
    else $error("edge did not set flag 0");
  a_level_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(level_mode[1]) |-> !flags_reg[1])
    else $error("flag 1 set in level mode");
  a_w1c_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_flags && reg_wdata[2] && !edge_event[2]) |=> !flags_reg[2])
    else $error("write one did not clear flag 2");
  a_w0_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_flags && !reg_wdata[0] && flags_reg[0] && !vector_entry[0]
     && !level_mode[0]) |=> flags_reg[0])
    else $error("write zero changed flag 0");
  a_vector_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vector_entry[1] && !edge_event[1]) |=> !flags_reg[1])
    else $error("vector entry did not clear flag 1");
  a_global_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !global_irq_enable |=> irq_request == '0)
    else $error("request without global enable");
  a_level_request: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (level_mode[0] && !ext_irq_pin[0] && enables_reg[0] && global_irq_enable)
    |=> irq_request[0])
    else $error("low level did not request");
  a_request_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq_request[2] |-> $past(enables_reg[2]) && $past(flags_reg[2] | level_low[2]))
    else $error("request 2 without cause");
  a_sense_io_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_io_space) |=> $stable(sense_reg))
    else $error("sense register written via short i/o");
  a_change_detect: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (level_mode == '0 && sense_reg[1:0] == 2'b01 && ext_irq_pin[0] != $past(ext_irq_pin[0]))
    |-> ##2 flags_reg[0] || $past(vector_entry[0]) || $past(reg_wr))
    else $error("change on pin 0 not flagged");

  // the same flag checks on the other pins; each pin has its own flops,
  // so a copy-paste slip in one lane would not show on another
  a_flag_on_edge1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (edge_event[1] && !level_mode[1]) |=> flags_reg[1])
    else $error("edge did not set flag 1");

  a_flag_on_edge2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (edge_event[2] && !level_mode[2]) |=> flags_reg[2])
    else $error("edge did not set flag 2");

  a_level_flag_clear0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(level_mode[0]) |-> !flags_reg[0])
    else $error("flag 0 set in level mode");

  a_level_flag_clear2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(level_mode[2]) |-> !flags_reg[2])
    else $error("flag 2 set in level mode");

  // software clears: a one clears, a zero keeps, unless an edge lands too
  a_w1c_clear0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_flags && reg_wdata[0] && !edge_event[0]) |=> !flags_reg[0])
    else $error("write one did not clear flag 0");

  a_w1c_clear1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_flags && reg_wdata[1] && !edge_event[1]) |=> !flags_reg[1])
    else $error("write one did not clear flag 1");

  a_w0_keep1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_flags && !reg_wdata[1] && flags_reg[1] && !vector_entry[1]
     && !level_mode[1]) |=> flags_reg[1])
    else $error("write zero changed flag 1");

  a_w0_keep2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_flags && !reg_wdata[2] && flags_reg[2] && !vector_entry[2]
     && !level_mode[2]) |=> flags_reg[2])
    else $error("write zero changed flag 2");

  // vector entry clears the flag of its own pin only
  a_vector_clear0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vector_entry[0] && !edge_event[0]) |=> !flags_reg[0])
    else $error("vector entry did not clear flag 0");

  a_vector_clear2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vector_entry[2] && !edge_event[2]) |=> !flags_reg[2])
    else $error("vector entry did not clear flag 2");

  // level requests follow the raw pin, one flop late
  a_level_request1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (level_mode[1] && !ext_irq_pin[1] && enables_reg[1] && global_irq_enable)
    |=> irq_request[1])
    else $error("low level did not request on pin 1");

  a_level_request2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (level_mode[2] && !ext_irq_pin[2] && enables_reg[2] && global_irq_enable)
    |=> irq_request[2])
    else $error("low level did not request on pin 2");

  a_request_cause0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq_request[0] |-> $past(enables_reg[0]) && $past(flags_reg[0] | level_low[0]))
    else $error("request 0 without cause");

  a_request_cause1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    irq_request[1] |-> $past(enables_reg[1]) && $past(flags_reg[1] | level_low[1]))
    else $error("request 1 without cause");

  // a cleared enable bit silences its pin whatever the flag holds
  a_enable_gate0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !enables_reg[0] |=> !irq_request[0])
    else $error("request 0 while disabled");

  a_enable_gate1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !enables_reg[1] |=> !irq_request[1])
    else $error("request 1 while disabled");

  a_enable_gate2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !enables_reg[2] |=> !irq_request[2])
    else $error("request 2 while disabled");

  // a pending, enabled flag must reach the processor on the next edge
  a_edge_request0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (flags_reg[0] && enables_reg[0] && global_irq_enable) |=> irq_request[0])
    else $error("flag 0 did not request");

  a_edge_request1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (flags_reg[1] && enables_reg[1] && global_irq_enable) |=> irq_request[1])
    else $error("flag 1 did not request");

  a_edge_request2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (flags_reg[2] && enables_reg[2] && global_irq_enable) |=> irq_request[2])
    else $error("flag 2 did not request");

  // no request survives once both its causes are gone
  a_request_drop0: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!flags_reg[0] && !level_low[0]) |=> !irq_request[0])
    else $error("request 0 without flag or level");

  a_request_drop1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!flags_reg[1] && !level_low[1]) |=> !irq_request[1])
    else $error("request 1 without flag or level");

  a_request_drop2: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!flags_reg[2] && !level_low[2]) |=> !irq_request[2])
    else $error("request 2 without flag or level");

  // edge direction: the detector sees the pin two and one samples back
  a_falling_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sense_reg[1:0] == 2'b10 && edge_event[0])
    |-> $past(ext_irq_pin[0], 2) && !$past(ext_irq_pin[0]))
    else $error("falling mode fired without a falling edge");

  a_rising_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sense_reg[1:0] == 2'b11 && edge_event[0])
    |-> !$past(ext_irq_pin[0], 2) && $past(ext_irq_pin[0]))
    else $error("rising mode fired without a rising edge");

  // read data: unused bits stay zero, unmapped addresses give zero
  a_sense_rd_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && sel_sense) |=> reg_rdata[7:6] == 2'b00)
    else $error("sense read shows unused bits");

  a_enable_rd_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && sel_enables) |=> reg_rdata[7:PINS] == '0)
    else $error("enable read shows unused bits");

  a_flag_rd_upper: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && sel_flags) |=> reg_rdata[7:PINS] == '0)
    else $error("flag read shows unused bits");

  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && !sel_flags && !sel_enables && !sel_sense) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // decode: the short window reaches flags and enables, never sense
  a_io_flag_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_io_space && reg_addr == 8'h1C) |-> sel_flags)
    else $error("short flag address not decoded");

  a_io_enable_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_io_space && reg_addr == 8'h1D) |-> sel_enables)
    else $error("short enable address not decoded");

  a_io_sense_never: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_io_space |-> !sel_sense)
    else $error("sense selected by short access");

  a_data_sense_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!reg_io_space && reg_addr == 8'h69) |-> sel_sense)
    else $error("sense data address not decoded");

  // writes land in the next cycle with the written bits only
  a_enable_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_enables) |=> enables_reg == $past(reg_wdata[PINS-1:0]))
    else $error("enable write lost");

  a_sense_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && sel_sense) |=> sense_reg == $past(reg_wdata[5:0]))
    else $error("sense write lost");
endmodule

// *** pin_source.sv ***
// model of the external sources that drive the three interrupt pins
`timescale 1ns/1ps
module pin_source
(
  // clock
  input  wire logic       clk_sys,
  // pins
  output logic [2:0]      ext_irq_pin
);
  // lines idle high as with a pull-up, so the reset state sees no edge
  initial ext_irq_pin = 3'h7;

  // move one pin at the falling edge, then hold it for a number of cycles;
  // holds under two cycles are stretched to two, a cycle more than a pulse needs to be seen
  task automatic drive(input int n, input logic v, input int hold);
    @(negedge clk_sys);
    ext_irq_pin[n] = v;
    repeat (hold < 2 ? 2 : hold) @(negedge clk_sys);
  endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
  logic       clk_sys           = 1'b0;
  logic       sys_rst           = 1'b1;
  logic [7:0] reg_addr          = 8'h00;
  logic       reg_io_space      = 1'b0;
  logic       reg_wr            = 1'b0;
  logic       reg_rd            = 1'b0;
  logic [7:0] reg_wdata         = 8'h00;
  logic       global_irq_enable = 1'b0;
  logic [2:0] vector_entry      = 3'h0;
  logic       look_irq          = 1'b0;
  logic       rd_q              = 1'b0;
  logic       look_q            = 1'b0;
  wire  [2:0] ext_irq_pin;
  logic [7:0] reg_rdata;
  logic [2:0] irq_request;
  logic [7:0] exp_rd[$];
  logic [2:0] exp_irq[$];
  logic [7:0] e_rd;
  logic [2:0] e_irq;
  int         errors            = 0;
  int         n_checks          = 0;
  int         cycles            = 0;

  external_pin_interrupt_unit #(.PINS(3)) u_external_pin_interrupt_unit
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ext_irq_pin(ext_irq_pin),
    .reg_addr(reg_addr), .reg_io_space(reg_io_space), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
    .vector_entry(vector_entry), .irq_request(irq_request)
  );
  pin_source u_pin_source (.clk_sys(clk_sys), .ext_irq_pin(ext_irq_pin));

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // note which cycles carry a result; read data is registered one cycle late
  always @(posedge clk_sys)
  begin
    rd_q   <= reg_rd;
    look_q <= look_irq;
    cycles <= cycles + 1;
  end

  // compare at the falling edge, where outputs have settled
  always @(negedge clk_sys)
  begin
    if (rd_q)
    begin
      e_rd = exp_rd.pop_front();
      `CHECK(reg_rdata, e_rd)
    end
    if (look_q)
    begin
      e_irq = exp_irq.pop_front();
      `CHECK(irq_request, e_irq)
    end
    if (cycles > 5000)
    begin
      errors++;
      final_report();
    end
  end

  // one register access; a read notes the value it expects
  task automatic acc(input logic [7:0] a, input logic io, input logic w, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr     = a;
    reg_io_space = io;
    reg_wdata    = d;
    reg_wr       = w;
    reg_rd       = ~w;
    if (!w) exp_rd.push_back(d);
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask

  // note the expected request lines for the next falling edge
  task automatic chk_irq(input logic [2:0] v);
    @(negedge clk_sys);
    exp_irq.push_back(v);
    look_irq = 1'b1;
    @(negedge clk_sys);
    look_irq = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence: reset, register map, every mode on every pin, masking
  initial
  begin
    void'($urandom(32'h0000_50b6));
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    acc(8'h3C, 0, 0, 8'h00);
    acc(8'h69, 0, 0, 8'h00);
    acc(8'h1D, 1, 0, 8'h00);
    chk_irq(3'h0);
    acc(8'h3D, 0, 1, 8'hFF);
    acc(8'h1D, 1, 0, 8'h07);
    acc(8'h69, 0, 1, 8'hFF);
    acc(8'h69, 0, 0, 8'h3F);
    acc(8'h49, 1, 1, 8'h00);
    acc(8'h69, 0, 0, 8'h3F);
    acc(8'h49, 1, 0, 8'h00);
    acc(8'h3E, 0, 0, 8'h00);
    global_irq_enable = 1'b1;
    // each pin in each sense mode: fall, clear, rise, then vector entry
    for (int n = 0; n < 3; n++)
      for (int m = 0; m < 4; m++)
      begin
        acc(8'h69, 0, 1, {2'b00, m[1:0], m[1:0], m[1:0]});
        acc(8'h1C, 1, 1, 8'h07);
        u_pin_source.drive(n, 1'b0, $urandom_range(5, 8));
        chk_irq(3'(m != 3) << n);
        acc(8'h3C, 0, 0, 8'(m == 1 || m == 2) << n);
        acc(8'h3C, 0, 1, 8'h07);
        u_pin_source.drive(n, 1'b1, $urandom_range(5, 8));
        acc(8'h3C, 0, 0, 8'(m == 1 || m == 3) << n);
        chk_irq(3'(m == 1 || m == 3) << n);
        vector_entry[n] = 1'b1;
        @(negedge clk_sys);
        vector_entry[n] = 1'b0;
        acc(8'h3C, 0, 0, 8'h00);
      end
    // global and per-pin enables gate a pending flag; writing zero keeps it
    acc(8'h69, 0, 1, 8'h2A);
    global_irq_enable = 1'b0;
    u_pin_source.drive(2, 1'b0, 6);
    chk_irq(3'h0);
    acc(8'h3C, 0, 1, 8'h00);
    acc(8'h3C, 0, 0, 8'h04);
    global_irq_enable = 1'b1;
    chk_irq(3'h4);
    acc(8'h1D, 1, 1, 8'h03);
    chk_irq(3'h0);
    u_pin_source.drive(2, 1'b1, 2);
    final_report();
  end
endmodule
